// ===== dv/periph_model.sv
// model of peripherals raising flag events and level conditions
`timescale 1ns/1ps
`default_nettype none
module periph_model #(
  parameter int N = 8
) (
  input wire logic pclk, // cpu clock
  input wire logic presetn, // async reset, active low
  input wire logic [N-1:0] fire, // one-shot event requests
  input wire logic [N-1:0] cond, // wanted level conditions
  output logic [N-1:0] src_event, // one-cycle event pulses
  output logic [N-1:0] src_level // level conditions
);
  // events last one cycle, levels follow the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_event <= '0;
      src_level <= '0;
    end else begin
      src_event <= fire;
      src_level <= cond;
    end
  end
endmodule : periph_model
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench for the interrupt entry unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  import irq_entry_pkg::*;
  localparam logic [PC_W-1:0] BOOT = 17'h1e000;
  logic pclk, presetn, psel, penable, pwrite, fuse, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [NUM_SRC-1:0] fire, cond, src_event, src_level;
  logic [PC_W-1:0] reset_vector;
  seq_cmd_s cmd;
  seq_rsp_s rsp;
  int n_fail, checks_done;

  irq_entry #(.N(NUM_SRC), .BOOT_START(BOOT)) i_dut (.pclk(pclk),
    .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_event(src_event),
    .src_level(src_level), .reset_vector_boot_fuse(fuse),
    .app_boot_lock_irq_bit(1'b0), .boot_section_lock_irq_bit(1'b0),
    .cmd(cmd), .rsp(rsp), .reset_vector(reset_vector));
  periph_model #(.N(NUM_SRC)) i_periph (.pclk(pclk), .presetn(presetn),
    .fire(fire), .cond(cond), .src_event(src_event), .src_level(src_level));

  // 200 MHz cpu clock
  always #2.5 pclk = ~pclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, result left in rd and err
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(negedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 50) n_fail++;
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic pulse(input logic [NUM_SRC-1:0] m);
    @(posedge pclk);
    fire <= m;
    @(posedge pclk);
    fire <= '0;
  endtask : pulse

  // hold boundary until entry starts, judge vector and delay
  task automatic take(input logic [PC_W-1:0] exp, input int min_cyc);
    int n;
    logic bsy;
    n = 0;
    @(posedge pclk);
    cmd.boundary <= 1'b1;
    while (n < 60) begin
      @(negedge pclk);
      if (rsp.vector_valid === 1'b1) break;
      bsy = (rsp.busy === 1'b1);
      @(posedge pclk);
      if (bsy) cmd.boundary <= 1'b0;
      n++;
    end
    chk({15'h0, rsp.vector}, {15'h0, exp});
    chk(32'(n >= min_cyc && n < 60), 32'h1);
    @(posedge pclk);
    cmd.boundary <= 1'b0;
  endtask : take

  task automatic ret();
    int n;
    n = 0;
    @(posedge pclk);
    cmd.boundary <= 1'b1;
    cmd.return_op <= 1'b1;
    @(posedge pclk);
    cmd.boundary <= 1'b0;
    cmd.return_op <= 1'b0;
    do begin
      @(posedge pclk);
      n++;
      @(negedge pclk);
    end while (rsp.busy === 1'b1 && n < 60);
    chk(32'(n >= RETURN_CYCLES && n < 60), 32'h1);
  endtask : ret

  // boundaries offered, yet no entry may start
  task automatic no_take(input logic dis);
    @(posedge pclk);
    cmd.boundary <= 1'b1;
    cmd.disable_op <= dis;
    @(posedge pclk);
    cmd.disable_op <= 1'b0;
    repeat (10) begin
      @(negedge pclk);
      chk({31'h0, rsp.busy | rsp.vector_valid}, 32'h0);
    end
    @(posedge pclk);
    cmd.boundary <= 1'b0;
  endtask : no_take

  task automatic t_reset();
    apb(0, ADDR_CTRL, 0);
    chk(rd, CTRL_RESET);
    apb(0, ADDR_SP, 0);
    chk(rd, {16'h0, SP_RESET});
    apb(0, ADDR_KIND, 0);
    chk(rd, 32'h0000_00ff);
    apb(0, 8'h1c, 0);
    chk({31'h0, err}, 32'h1);
    chk({15'h0, reset_vector}, 32'h0);
  endtask : t_reset

  task automatic t_prio();
    apb(1, ADDR_ENABLE, 32'h0000_0024);
    pulse(8'h24);
    apb(0, ADDR_FLAG, 0);
    chk(rd, 32'h0000_0024);
    no_take(1'b0);
    apb(1, ADDR_CTRL, 32'h0000_0001);
    take(PC_W'(VEC_STEP * 3), ENTRY_CYCLES);
    apb(0, ADDR_CTRL, 0);
    chk(rd, 32'h0);
    apb(0, ADDR_FLAG, 0);
    chk(rd, 32'h0000_0020);
    apb(0, ADDR_SP, 0);
    chk(rd, {16'h0, SP_RESET - RET_ADDR_BYTES});
    ret();
    apb(0, ADDR_CTRL, 0);
    chk(rd, 32'h0000_0001);
    apb(0, ADDR_SP, 0);
    chk(rd, {16'h0, SP_RESET});
    take(PC_W'(VEC_STEP * 6), ENTRY_CYCLES);
    ret();
  endtask : t_prio

  task automatic t_cli();
    apb(1, ADDR_ENABLE, 32'h0000_0008);
    pulse(8'h08);
    no_take(1'b1);
    apb(0, ADDR_CTRL, 0);
    chk(rd, 32'h0);
    apb(1, ADDR_FLAG, 32'h0);
    apb(0, ADDR_FLAG, 0);
    chk(rd, 32'h0000_0008);
    apb(1, ADDR_FLAG, 32'h0000_0008);
    apb(0, ADDR_FLAG, 0);
    chk(rd, 32'h0);
    pulse(8'h08);
    @(posedge pclk);
    cmd.enable_op <= 1'b1;
    @(posedge pclk);
    cmd.enable_op <= 1'b0;
    take(PC_W'(VEC_STEP * 4), ENTRY_CYCLES + 2);
    ret();
  endtask : t_cli

  task automatic t_level();
    apb(1, ADDR_KIND, 32'h0000_00bf);
    apb(1, ADDR_ENABLE, 32'h0000_0040);
    cond <= 8'h40;
    cmd.sleeping <= 1'b1;
    apb(1, ADDR_CTRL, 32'h0000_0003);
    take(BOOT + PC_W'(VEC_STEP * 7), 10);
    cmd.sleeping <= 1'b0;
    cond <= '0;
    ret();
    no_take(1'b0);
    fuse <= 1'b1;
    repeat (6) @(posedge pclk);
    @(negedge pclk);
    chk({15'h0, reset_vector}, {15'h0, BOOT});
  endtask : t_level

  task automatic wrap_up();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, fuse} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {fire, cond} = 16'h0;
    cmd = '0;
    cmd.pc = 17'h00100;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_prio();
    t_cli();
    t_level();
    wrap_up();
  end

  // watchdog against a hang
  initial begin
    #100000;
    n_fail++;
    wrap_up();
  end
endmodule : tb
`default_nettype wire

// ===== src/irq_entry.sv
// interrupt gating, priority, entry and return sequencer with apb registers
// Contract
// RULE1: take a source only when its enable and global enable are set
// RULE2: suppress interrupts by pc region when a boot lock irq bit is set
// RULE3: lowest vector index wins; reset first, external request zero next
// RULE4: vectors at address zero, or boot start when relocate select set
// RULE5: reset vector at boot start when reset vector boot fuse programmed
// RULE6: accepting an interrupt clears the global enable
// RULE7: software setting global enable in a handler allows nesting
// RULE8: return from interrupt sets global enable
// RULE9: flag-type source flag cleared by hardware on vectoring
// RULE10: writing one clears a flag, writing zero leaves it
// RULE11: flag set while disabled stays until enabled or cleared
// RULE12: pending flags served in priority order once global enable set
// RULE13: level sources request only while their condition is present
// RULE14: after return run one instruction before next interrupt
// RULE15: status word not saved on entry nor restored on return
// RULE16: disable instruction blocks interrupts in its own cycle
// RULE17: after enable instruction run next instruction first
// RULE18: entry takes five cycles, pushes pc, then jumps to vector
// RULE19: interrupts wait for multi-cycle instruction completion
// RULE20: wake from sleep adds five cycles to entry
// RULE21: return takes five cycles, pops pc, sp plus three, sets enable
// RULE22: entry decrements stack pointer by three
// RULE23: arbitrate only at boundaries, one winner per entry
`timescale 1ns/1ps
`default_nettype none
module irq_entry #(
  parameter int N = irq_entry_pkg::NUM_SRC,
  parameter logic [irq_entry_pkg::PC_W-1:0] BOOT_START =
    irq_entry_pkg::BOOT_START_DEF
) (
  input wire logic pclk, // cpu clock
  input wire logic presetn, // async reset, active low
  input wire logic clk_en, // freezes all state when low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [N-1:0] src_event, // flag-type event pulses
  input wire logic [N-1:0] src_level, // level-type conditions
  input wire logic reset_vector_boot_fuse, // fuse strap
  input wire logic app_boot_lock_irq_bit, // lock in application region
  input wire logic boot_section_lock_irq_bit, // lock in boot region
  input wire irq_entry_pkg::seq_cmd_s cmd, // sequencer command
  output irq_entry_pkg::seq_rsp_s rsp, // answer to sequencer
  output logic [irq_entry_pkg::PC_W-1:0] reset_vector // reset start address
);
  import irq_entry_pkg::*;

  localparam logic [2:0] ENTRY_LAST = 3'(ENTRY_CYCLES - 1);
  localparam logic [2:0] WAKE_LAST = 3'(WAKE_EXTRA_CYCLES - 1);
  localparam logic [2:0] RET_LAST = 3'(RETURN_CYCLES - 1);

  logic [31:0] cpu_control_register_q;
  logic [N-1:0] enable_q, flag_q, kind_q;
  logic [SP_W-1:0] sp_q;
  logic [PC_W-1:0] ret_pc_q, vec_q;
  logic [$clog2(N)-1:0] win_q;
  logic win_flag_q;
  seq_state_e state_q;
  logic [2:0] cnt_q;
  logic hold_q; // one-instruction grace after enable or return
  logic strap_a_q, strap_b_q, strap_q; // fuse pin synchroniser

  // picks the lowest pending index
  function automatic logic [$clog2(N):0] pick(input logic [N-1:0] r);
    logic [$clog2(N):0] v;
    v = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (r[i]) begin
        v = {1'b1, ($clog2(N))'(i)};
      end
    end
    return v;
  endfunction : pick

  wire logic gie = cpu_control_register_q[CTRL_GIE];
  wire logic in_boot = (cmd.pc >= BOOT_START);
  wire logic locked = in_boot ? boot_section_lock_irq_bit :
                      app_boot_lock_irq_bit; // [RULE2]
  // flags for flag-type sources, live level for level-type
  wire logic [N-1:0] req = ((flag_q & kind_q) | (src_level & ~kind_q))
                          & enable_q; // [RULE1] [RULE11] [RULE13]
  wire logic [$clog2(N):0] sel = pick(req); // [RULE3]
  wire logic take = (state_q == ST_RUN) && cmd.boundary && sel[$clog2(N)]
                    && gie && !cmd.disable_op && !hold_q && !locked;
  // [RULE1] [RULE16] [RULE19] [RULE23]
  wire logic [PC_W-1:0] vbase =
    cpu_control_register_q[CTRL_VRS] ? BOOT_START : '0; // [RULE4]
  wire logic wr = psel && penable && pwrite;
  wire logic entry_done = (state_q == ST_ENTRY) && (cnt_q == ENTRY_LAST);
  wire logic ret_done = (state_q == ST_RETURN) && (cnt_q == RET_LAST);

  // apb slave, zero wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= '0;
      if (psel && !penable) begin
        case (paddr)
          ADDR_CTRL: prdata <= cpu_control_register_q;
          ADDR_ENABLE: prdata <= 32'(enable_q);
          ADDR_FLAG: prdata <= 32'(flag_q);
          ADDR_KIND: prdata <= 32'(kind_q);
          ADDR_STATUS: prdata <= {24'h000000, 3'(state_q), cnt_q,
                                   hold_q, locked};
          ADDR_SP: prdata <= 32'(sp_q);
          ADDR_PC: prdata <= 32'(ret_pc_q);
          default: pslverr <= 1'b0;
        endcase
        if (!(paddr inside {ADDR_CTRL, ADDR_ENABLE, ADDR_FLAG, ADDR_KIND,
                            ADDR_STATUS, ADDR_SP, ADDR_PC})) begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // control register: global enable and vector relocate select
  // status word is not stacked: only the enable bit moves here [RULE15]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_control_register_q <= CTRL_RESET;
    end else if (clk_en) begin
      if (wr && pready && paddr == ADDR_CTRL) begin
        cpu_control_register_q <= pwdata & 32'h0000_0003; // [RULE7]
      end
      if (cmd.enable_op) begin
        cpu_control_register_q[CTRL_GIE] <= 1'b1;
      end
      if (cmd.disable_op || take) begin
        cpu_control_register_q[CTRL_GIE] <= 1'b0; // [RULE6] [RULE16]
      end
      if (ret_done) begin
        cpu_control_register_q[CTRL_GIE] <= 1'b1; // [RULE8] [RULE21]
      end
    end
  end

  // enables and source kinds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= '0;
      kind_q <= '1;
    end else if (clk_en && wr && pready) begin
      if (paddr == ADDR_ENABLE) begin
        enable_q <= pwdata[N-1:0];
      end
      if (paddr == ADDR_KIND) begin
        kind_q <= pwdata[N-1:0];
      end
    end
  end

  // true when source i is the current winner
  function automatic logic win_sel_is(input int i);
    return sel[$clog2(N)-1:0] == ($clog2(N))'(i);
  endfunction : win_sel_is

  // sticky flags: events win over both clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < N; i++) begin
        if (src_event[i] && kind_q[i]) begin
          flag_q[i] <= 1'b1; // [RULE11] [RULE12]
        end else if (wr && pready && paddr == ADDR_FLAG && pwdata[i]) begin
          flag_q[i] <= 1'b0; // [RULE10]
        end else if (take && win_sel_is(i)) begin
          flag_q[i] <= 1'b0; // [RULE9]
        end
      end
    end
  end

  // entry and return sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_RUN;
      cnt_q <= '0;
      win_q <= '0;
      win_flag_q <= 1'b0;
      vec_q <= '0;
      ret_pc_q <= '0;
    end else if (clk_en) begin
      case (state_q)
        ST_RUN: begin
          cnt_q <= '0;
          if (take) begin
            win_q <= sel[$clog2(N)-1:0];
            win_flag_q <= kind_q[sel[$clog2(N)-1:0]];
            // slot 0 is reset, so source i sits at slot i+1 [RULE3]
            vec_q <= vbase + VEC_STEP * PC_W'(32'(sel[$clog2(N)-1:0]) + 1);
            ret_pc_q <= cmd.pc;
            state_q <= cmd.sleeping ? ST_WAKE : ST_ENTRY; // [RULE20]
          end else if (cmd.return_op && cmd.boundary) begin
            state_q <= ST_RETURN;
          end
        end
        ST_WAKE: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == WAKE_LAST) begin
            cnt_q <= '0;
            state_q <= ST_ENTRY;
          end
        end
        ST_ENTRY: begin
          cnt_q <= cnt_q + 3'h1;
          if (entry_done) begin
            cnt_q <= '0;
            state_q <= ST_RUN; // [RULE18]
          end
        end
        ST_RETURN: begin
          cnt_q <= cnt_q + 3'h1;
          if (ret_done) begin
            cnt_q <= '0;
            state_q <= ST_GAP; // [RULE21]
          end
        end
        ST_GAP: state_q <= ST_RUN;
        default: state_q <= ST_RUN;
      endcase
    end
  end

  // grace of one instruction after return or enable instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 1'b0;
    end else if (clk_en) begin
      if (ret_done || (cmd.enable_op && !gie)) begin
        hold_q <= 1'b1; // [RULE14] [RULE17]
      end else if (cmd.boundary && state_q == ST_RUN) begin
        hold_q <= 1'b0;
      end
    end
  end

  // stack pointer: three bytes down on entry, three up on return
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_q <= SP_RESET;
    end else if (clk_en) begin
      if (wr && pready && paddr == ADDR_SP) begin
        sp_q <= pwdata[SP_W-1:0];
      end else if (entry_done) begin
        sp_q <= sp_q - RET_ADDR_BYTES; // [RULE22]
      end else if (ret_done) begin
        sp_q <= sp_q + RET_ADDR_BYTES; // [RULE21]
      end
    end
  end

  // sequencer answer and reset vector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp <= '0;
      reset_vector <= '0;
      strap_a_q <= 1'b0;
      strap_b_q <= 1'b0;
      strap_q <= 1'b0;
    end else if (clk_en) begin
      strap_a_q <= reset_vector_boot_fuse;
      strap_b_q <= strap_a_q;
      strap_q <= strap_b_q;
      // fuse change counts once the last two stages agree
      if (strap_b_q == strap_q) begin
        reset_vector <= strap_q ? BOOT_START : '0; // [RULE5]
      end
      rsp.busy <= take || (state_q != ST_RUN && state_q != ST_GAP
                  && !entry_done && !ret_done);
      rsp.vector_valid <= entry_done;
      rsp.vector <= vec_q;
      rsp.push <= (state_q == ST_ENTRY) && (cnt_q < 3'h3);
      rsp.pop <= (state_q == ST_RETURN) && (cnt_q < 3'h3);
    end
  end

  // entry lasts exactly five cycles once begun
  chk_entry_len: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && state_q == ST_RUN && take && !cmd.sleeping) ##1 clk_en[*4]
    |-> ##1 entry_done || !clk_en) else $error("entry length wrong"); // [RULE18]
  chk_take_clears_gie: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && take) |=> !gie) else $error("enable not cleared"); // [RULE6]
  chk_ret_sets_gie: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && ret_done) |=> gie) else $error("return left enable off"); // [RULE8]
  chk_disable_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    cmd.disable_op |-> !take) else $error("taken on disable"); // [RULE16]
  chk_gated_take: assert property (@(posedge pclk) disable iff (!presetn)
    take |-> gie && enable_q[sel[$clog2(N)-1:0]]) else $error("ungated"); // [RULE1]
  chk_ret_sp_up: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && ret_done && !(wr && pready && paddr == ADDR_SP))
    |=> sp_q == $past(sp_q) + RET_ADDR_BYTES) else $error("sp pop"); // [RULE21]
  chk_entry_sp_down: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && entry_done && !(wr && pready && paddr == ADDR_SP))
    |=> sp_q == $past(sp_q) - RET_ADDR_BYTES) else $error("sp push"); // [RULE22]
  chk_grace_after_ret: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && ret_done) |=> !take) else $error("no grace"); // [RULE14]
  chk_lock_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    locked |-> !take) else $error("taken under lock"); // [RULE2]
endmodule : irq_entry
`default_nettype wire

// ===== src/irq_entry_pkg.sv
// shared constants, types and register map for the interrupt entry unit
package irq_entry_pkg;
  localparam int NUM_SRC = 8;
  localparam int PC_W = 17;
  localparam int SP_W = 16;
  localparam int ENTRY_CYCLES = 5;
  localparam int WAKE_EXTRA_CYCLES = 5;
  localparam int RETURN_CYCLES = 5;
  localparam logic [SP_W-1:0] RET_ADDR_BYTES = 16'h0003;
  localparam logic [SP_W-1:0] SP_RESET = 16'h21ff;
  localparam logic [PC_W-1:0] VEC_STEP = 17'h00002;
  localparam logic [PC_W-1:0] BOOT_START_DEF = 17'h1f000;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ENABLE = 8'h04;
  localparam logic [7:0] ADDR_FLAG = 8'h08;
  localparam logic [7:0] ADDR_KIND = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_SP = 8'h14;
  localparam logic [7:0] ADDR_PC = 8'h18;
  // control register bit positions
  localparam int CTRL_GIE = 0;
  localparam int CTRL_VRS = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_RUN, ST_WAKE, ST_ENTRY, ST_RETURN, ST_GAP
  } seq_state_e;

  // command from the instruction sequencer
  typedef struct packed {
    logic boundary;    // instruction boundary reached
    logic disable_op;  // interrupt-disable instruction
    logic enable_op;   // interrupt-enable instruction
    logic return_op;   // return_from_irq_op
    logic sleeping;    // core asleep
    logic [PC_W-1:0] pc; // current program counter
  } seq_cmd_s;

  // entry/return answer to the sequencer
  typedef struct packed {
    logic busy;
    logic vector_valid;
    logic [PC_W-1:0] vector;
    logic push;
    logic pop;
  } seq_rsp_s;
endpackage : irq_entry_pkg
